// ### design/sgia_edge_flag.sv
// Sticky event flag: set on rising source, write-one-to-clear, set wins
`timescale 1ns/100ps
module sgia_edge_flag (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Event and clear
    input wire logic src_in,
    input wire logic clr_in,
    // Flag
    output logic flag_out
);
    logic src_q;
    logic flag_q;
    logic rise;
    logic flag_d;

    assign rise = src_in & ~src_q;
    // Set beats a clear in the same cycle
    assign flag_d = rise | (flag_q & ~clr_in);
    assign flag_out = flag_q;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            src_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            src_q <= src_in;
            flag_q <= flag_d;
        end
    end

    a_flag_set_wins: assert property (@(posedge mclk_in) disable iff (rst_in)
        rise |=> flag_q)
        else $error("event rise did not set flag");
endmodule // sgia_edge_flag

// ### design/sgia_pkg.sv
// Package: register map, fields and reset values of the global interrupt aggregator
package sgia_pkg;
    // ********************************************
    // Register offsets (byte addresses)
    // ********************************************
    localparam logic [7:0] SGIA_OFF_GSTAT = 8'h10;
    localparam logic [7:0] SGIA_OFF_GMASK = 8'h14;
    localparam logic [7:0] SGIA_OFF_PSTAT = 8'h18;
    localparam logic [7:0] SGIA_OFF_PMASK = 8'h1c;
    localparam logic [7:0] SGIA_OFF_EVST = 8'h20;
    localparam logic [7:0] SGIA_OFF_EVMSK = 8'h24;
    // ********************************************
    // Field positions and widths
    // ********************************************
    localparam int SGIA_ALE_BIT = 31;
    localparam int SGIA_NPORT = 7;
    localparam logic [6:0] SGIA_PORT_VALID = 7'h6f;
    localparam logic [31:0] SGIA_GMASK_WMASK = 32'h80000000;
    localparam logic [31:0] SGIA_PMASK_WMASK = 32'h0000006f;
    localparam logic [31:0] SGIA_EV_WMASK = 32'h8000006f;
    // ********************************************
    // Reset values
    // ********************************************
    localparam logic SGIA_ALE_MASK_RST = 1'b0;
    localparam logic [6:0] SGIA_PMASK_RST = 7'h00;
    localparam logic [31:0] SGIA_EV_RST = 32'h00000000;
    localparam logic [31:0] SGIA_RDATA_UNMAPPED = 32'h00000000;
    // ********************************************
    // Bus slave states
    // ********************************************
    typedef enum logic [1:0] {
        SGIA_ST_IDLE = 2'b01,
        SGIA_ST_ACK = 2'b10
    } sgia_bus_state_type;
endpackage

// ### design/sgia_top.sv
// Switch global interrupt aggregator with Avalon-MM register slave
// Behaviour
// - Global mask gates global status sources
// - Lookup-engine mask bit 31, reset zero, zero enables
// - Read-only port summary status register
// - Ports 1-4 bits 0-3, 6 bit5, 7 bit6
// - Summary bit one when port requests, reset zero
// - Port mask per port, reset zero, zero enables
// - Summary bit follows port detailed status
// - Global status bit 31 shows lookup-engine status, not gated by the mask
`timescale 1ns/100ps
module sgia_top
    import sgia_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Interrupt sources
    input wire logic address_lookup_engine_irq_in,
    input wire logic [6:0] port_detail_irq_in,
    // Interrupt outputs
    output logic switch_irq_out,
    output logic event_irq_out
);
    import sgia_pkg::*;

    // ********************************************
    // Register state
    // ********************************************
    sgia_bus_state_type state_q;
    sgia_bus_state_type state_d;
    logic ale_mask_q;
    logic [6:0] port_mask_q;
    logic [6:0] port_stat_q;
    logic ale_stat_q;
    logic [31:0] ev_mask_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] be_mask;
    wire logic [31:0] ev_stat;
    logic [31:0] ev_src;

    // ********************************************
    // Live status capture
    // ********************************************
    // Summary bits follow detailed sources; registered to give a clean read value
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            port_stat_q <= 7'h00;
            ale_stat_q <= 1'b0;
        end else begin
            port_stat_q <= port_detail_irq_in & SGIA_PORT_VALID;
            ale_stat_q <= address_lookup_engine_irq_in;
        end
    end

    // ********************************************
    // Bus decode
    // ********************************************
    wire req = avs_read_in | avs_write_in;
    wire take = (state_q == SGIA_ST_IDLE) && req;
    // Writes land at the accepting edge, where waitrequest is low
    wire wr_take = (state_q == SGIA_ST_ACK) && avs_write_in;
    wire hit_gmask = avs_address_in == SGIA_OFF_GMASK;
    wire hit_pmask = avs_address_in == SGIA_OFF_PMASK;
    wire hit_gstat = avs_address_in == SGIA_OFF_GSTAT;
    wire hit_pstat = avs_address_in == SGIA_OFF_PSTAT;
    wire hit_evst = avs_address_in == SGIA_OFF_EVST;
    wire hit_evmsk = avs_address_in == SGIA_OFF_EVMSK;
    wire [31:0] gstat_val = {ale_stat_q, 31'h0};
    wire [31:0] gmask_val = {ale_mask_q, 31'h0};
    wire [31:0] pstat_val = {25'h0, port_stat_q};
    wire [31:0] pmask_val = {25'h0, port_mask_q};
    wire [31:0] wdata_be = avs_writedata_in & be_mask;
    wire ev_clr_wr = wr_take && hit_evst;

    assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    // Read mux; unmapped reads answer zero
    assign rdata_d = hit_gstat ? gstat_val :
                     hit_gmask ? gmask_val :
                     hit_pstat ? pstat_val :
                     hit_pmask ? pmask_val :
                     hit_evst ? ev_stat :
                     hit_evmsk ? ev_mask_q : SGIA_RDATA_UNMAPPED;

    // One wait cycle: request taken in IDLE, answered in ACK
    assign state_d = take ? SGIA_ST_ACK : SGIA_ST_IDLE;
    assign avs_waitrequest_out = req && (state_q != SGIA_ST_ACK);
    assign avs_readdata_out = rdata_q;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SGIA_ST_IDLE;
            rdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            if (take && avs_read_in) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // ********************************************
    // Mask registers
    // ********************************************
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ale_mask_q <= SGIA_ALE_MASK_RST;
            port_mask_q <= SGIA_PMASK_RST;
            ev_mask_q <= SGIA_EV_RST;
        end else begin
            if (wr_take && hit_gmask && avs_byteenable_in[3]) begin
                ale_mask_q <= avs_writedata_in[SGIA_ALE_BIT];
            end
            if (wr_take && hit_pmask && avs_byteenable_in[0]) begin
                port_mask_q <= avs_writedata_in[6:0] & SGIA_PORT_VALID;
            end
            if (wr_take && hit_evmsk) begin
                ev_mask_q <= (ev_mask_q & ~be_mask) | (wdata_be & SGIA_EV_WMASK);
            end
        end
    end

    // ********************************************
    // Combined interrupt
    // ********************************************
    // global and port mask gating
    wire ale_pend = ale_stat_q & ~ale_mask_q;
    wire [6:0] port_pend = port_stat_q & ~port_mask_q;
    assign switch_irq_out = ale_pend | (|port_pend);

    // ********************************************
    // Sticky event status
    // ********************************************
    // Level status can vanish before software looks; these keep the edge
    assign ev_src = {ale_stat_q, 24'h0, port_stat_q};
    wire [31:0] ev_clr = ev_clr_wr ? (wdata_be & SGIA_EV_WMASK) : 32'h0;
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_ev
            if (SGIA_EV_WMASK[gi]) begin : g_on
                sgia_edge_flag u_flag (
                    .mclk_in(mclk_in),
                    .rst_in(rst_in),
                    .src_in(ev_src[gi]),
                    .clr_in(ev_clr[gi]),
                    .flag_out(ev_stat[gi])
                );
            end else begin : g_off
                assign ev_stat[gi] = 1'b0;
            end
        end
    endgenerate
    assign event_irq_out = |(ev_stat & ~ev_mask_q);

    // ********************************************
    // Checks: bus handshake
    // ********************************************
    // Bus answer after one wait
    a_bus_answer: assert property (@(posedge mclk_in) disable iff (rst_in)
        take |=> (state_q == SGIA_ST_ACK) && !avs_waitrequest_out)
        else $error("bus answer late");
    // Bus wait while taking
    a_bus_wait_take: assert property (@(posedge mclk_in) disable iff (rst_in)
        take |-> avs_waitrequest_out)
        else $error("request taken without wait");
    // Bus idle never stalls
    a_bus_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
        !req |-> !avs_waitrequest_out)
        else $error("waitrequest without a request");
    // Read data held between reads
    a_rdata_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        !(take && avs_read_in) |=> $stable(avs_readdata_out))
        else $error("read data changed without a read");

    // ********************************************
    // Checks: registers
    // ********************************************
    // mask write stored
    a_gmask_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_take && hit_gmask && avs_byteenable_in[3])
        |=> ale_mask_q == $past(avs_writedata_in[SGIA_ALE_BIT]))
        else $error("global mask write not stored");
    a_gmask_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        !(wr_take && hit_gmask && avs_byteenable_in[3]) |=> $stable(ale_mask_q))
        else $error("global mask changed without write");
    a_gmask_read: assert property (@(posedge mclk_in) disable iff (rst_in)
        (take && avs_read_in && hit_gmask)
        |=> avs_readdata_out == {$past(ale_mask_q), 31'h0})
        else $error("global mask read wrong");
    a_pmask_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_take && hit_pmask && avs_byteenable_in[0])
        |=> port_mask_q == ($past(avs_writedata_in[6:0]) & SGIA_PORT_VALID))
        else $error("port mask write not stored");
    a_pmask_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        !(wr_take && hit_pmask && avs_byteenable_in[0]) |=> $stable(port_mask_q))
        else $error("port mask changed without write");
    a_pmask_read: assert property (@(posedge mclk_in) disable iff (rst_in)
        (take && avs_read_in && hit_pmask)
        |=> avs_readdata_out == {25'h0, $past(port_mask_q)})
        else $error("port mask read wrong");
    a_pstat_ro: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_take && hit_pstat && port_detail_irq_in == 7'h0) |=> port_stat_q == 7'h0)
        else $error("status register took a write");
    a_pstat_read: assert property (@(posedge mclk_in) disable iff (rst_in)
        (take && avs_read_in && hit_pstat)
        |=> avs_readdata_out == {25'h0, $past(port_stat_q)})
        else $error("port status read wrong");
    a_pstat_rsvd: assert property (@(posedge mclk_in) disable iff (rst_in)
        port_stat_q[4] == 1'b0 && port_mask_q[4] == 1'b0)
        else $error("reserved bit 4 set");
    a_rsvd_read: assert property (@(posedge mclk_in) disable iff (rst_in)
        (take && avs_read_in && (hit_pstat || hit_pmask))
        |=> (avs_readdata_out[31:7] == 25'h0) && !avs_readdata_out[4])
        else $error("reserved bits read nonzero");
    // Event mask write stored
    a_evmask_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wr_take && hit_evmsk && avs_byteenable_in[0])
        |=> ev_mask_q[6:0] == ($past(avs_writedata_in[6:0]) & SGIA_PORT_VALID))
        else $error("event mask write not stored");

    // ********************************************
    // Checks: status and interrupts
    // ********************************************
    // summary follows detail
    a_pstat_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> port_stat_q == ($past(port_detail_irq_in) & SGIA_PORT_VALID))
        else $error("summary does not follow detail");
    a_pstat_set: assert property (@(posedge mclk_in) disable iff (rst_in)
        (|(port_detail_irq_in & SGIA_PORT_VALID)) |=> (|port_stat_q))
        else $error("port request not reported");
    a_ale_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
        1'b1 |=> ale_stat_q == $past(address_lookup_engine_irq_in))
        else $error("lookup status does not follow source");
    a_gstat_read: assert property (@(posedge mclk_in) disable iff (rst_in)
        (take && avs_read_in && hit_gstat) |=> avs_readdata_out[31] == $past(ale_stat_q))
        else $error("global status read wrong");
    a_irq_unmasked_port: assert property (@(posedge mclk_in) disable iff (rst_in)
        (|(port_stat_q & ~port_mask_q)) |-> switch_irq_out)
        else $error("unmasked port did not raise interrupt");
    a_irq_ale_masked: assert property (@(posedge mclk_in) disable iff (rst_in)
        (ale_mask_q && port_pend == 7'h0) |-> !switch_irq_out)
        else $error("masked lookup engine raised interrupt");
    a_irq_ale_path: assert property (@(posedge mclk_in) disable iff (rst_in)
        (address_lookup_engine_irq_in && !ale_mask_q && !(wr_take && hit_gmask))
        |=> switch_irq_out)
        else $error("lookup engine interrupt lost");
    a_irq_ale_unmasked: assert property (@(posedge mclk_in) disable iff (rst_in)
        ale_pend |-> switch_irq_out)
        else $error("pending lookup engine did not raise interrupt");
    a_irq_all_masked: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!ale_pend && port_pend == 7'h0) |-> !switch_irq_out)
        else $error("interrupt without unmasked source");
    // Unmasked event raises
    a_event_irq: assert property (@(posedge mclk_in) disable iff (rst_in)
        (|(ev_stat & ~ev_mask_q)) |-> event_irq_out)
        else $error("unmasked event did not raise interrupt");

    // ********************************************
    // Coverage of main scenarios
    // ********************************************
    // Raise, mask write, event clear, lookup pending, status read
    c_port_irq: cover property (@(posedge mclk_in) disable iff (rst_in)
        $rose(switch_irq_out));
    c_mask_write: cover property (@(posedge mclk_in) disable iff (rst_in)
        wr_take && hit_gmask);
    c_event_clear: cover property (@(posedge mclk_in) disable iff (rst_in)
        ev_clr_wr && (|ev_stat));
    c_ale_pend: cover property (@(posedge mclk_in) disable iff (rst_in)
        ale_pend);
    c_pstat_read: cover property (@(posedge mclk_in) disable iff (rst_in)
        take && avs_read_in && hit_pstat);
endmodule // sgia_top

// ### testbench/testbench.sv
// Self-checking testbench for the switch global interrupt aggregator
`timescale 1ns/100ps
module testbench;
    import sgia_pkg::*;
    logic mclk_in;
    logic rst_in;
    logic [7:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic address_lookup_engine_irq_in;
    logic [6:0] port_detail_irq_in;
    logic switch_irq_out;
    logic event_irq_out;
    int fail_count;
    int check_count;
    logic [31:0] rd;
    logic [31:0] gm;
    logic [31:0] pm;
    logic sa;
    logic [6:0] sp;

    sgia_top dut_u (
        .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .address_lookup_engine_irq_in(address_lookup_engine_irq_in),
        .port_detail_irq_in(port_detail_irq_in), .switch_irq_out(switch_irq_out),
        .event_irq_out(event_irq_out)
    );

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    task automatic wrap_up;
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low, then releases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        // Waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 20);
        if (avs_waitrequest_out !== 1'b0) begin
            fail_count++;
            wrap_up();
        end
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk(q, e);
    endtask

    // Zero mask bit lets its source through
    function automatic logic exp_irq(input logic a, input logic [6:0] p,
                                     input logic [31:0] g, input logic [31:0] m);
        return (a & ~g[31]) | (|(p & 7'h6f & ~m[6:0]));
    endfunction

    initial begin
        rst_in = 1'b1;
        avs_address_in = 8'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hf;
        address_lookup_engine_irq_in = 1'b0;
        port_detail_irq_in = 7'h00;
        fail_count = 0;
        check_count = 0;
        void'($urandom(32'h9c71));
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        rdchk(SGIA_OFF_GSTAT, 32'h0);
        rdchk(SGIA_OFF_GMASK, 32'h0);
        rdchk(SGIA_OFF_PSTAT, 32'h0);
        rdchk(SGIA_OFF_PMASK, 32'h0);
        rdchk(8'h40, 32'h0);
        wr(SGIA_OFF_GMASK, 32'hffffffff);
        rdchk(SGIA_OFF_GMASK, 32'h80000000);
        wr(SGIA_OFF_PMASK, 32'hffffffff);
        rdchk(SGIA_OFF_PMASK, 32'h0000006f);
        wr(SGIA_OFF_PSTAT, 32'hffffffff);
        rdchk(SGIA_OFF_PSTAT, 32'h0);
        // Top byte disabled keeps bit 31
        bus(1'b1, SGIA_OFF_GMASK, 32'h0, 4'h7, rd);
        rdchk(SGIA_OFF_GMASK, 32'h80000000);
        // Random sources and masks, first two all-open and all-shut
        for (int i = 0; i < 30; i++) begin
            gm = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
            pm = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
            sa = (i < 2) ? 1'b1 : 1'($urandom);
            sp = (i < 2) ? 7'h7f : 7'($urandom);
            wr(SGIA_OFF_GMASK, gm);
            wr(SGIA_OFF_PMASK, pm);
            gm = gm & 32'h80000000;
            pm = pm & 32'h0000006f;
            @(posedge mclk_in);
            address_lookup_engine_irq_in <= sa;
            port_detail_irq_in <= sp;
            rdchk(SGIA_OFF_GSTAT, {sa, 31'h0});
            rdchk(SGIA_OFF_PSTAT, {25'h0, sp & 7'h6f});
            rdchk(SGIA_OFF_PMASK, pm);
            @(negedge mclk_in);
            chk({31'h0, switch_irq_out}, {31'h0, exp_irq(sa, sp, gm, pm)});
        end
        // Mid-run reset drops both masks back to enabled
        wr(SGIA_OFF_GMASK, 32'hffffffff);
        wr(SGIA_OFF_PMASK, 32'hffffffff);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rdchk(SGIA_OFF_GMASK, 32'h0);
        rdchk(SGIA_OFF_PMASK, 32'h0);
        @(negedge mclk_in);
        chk({31'h0, switch_irq_out}, {31'h0, exp_irq(sa, sp, 32'h0, 32'h0)});
        // Sticky event: pulse on port 3, then write-one-to-clear
        @(posedge mclk_in);
        address_lookup_engine_irq_in <= 1'b0;
        port_detail_irq_in <= 7'h00;
        wr(SGIA_OFF_EVST, 32'hffffffff);
        // Zero event mask bit enables; only port 3 left open
        wr(SGIA_OFF_EVMSK, 32'hfffffffb);
        rdchk(SGIA_OFF_EVMSK, 32'h8000006b);
        rdchk(SGIA_OFF_EVST, 32'h0);
        @(posedge mclk_in);
        port_detail_irq_in <= 7'h04;
        @(posedge mclk_in);
        port_detail_irq_in <= 7'h00;
        rdchk(SGIA_OFF_EVST, 32'h00000004);
        @(negedge mclk_in);
        chk({31'h0, event_irq_out}, 32'h1);
        wr(SGIA_OFF_EVST, 32'h00000004);
        rdchk(SGIA_OFF_EVST, 32'h0);
        @(negedge mclk_in);
        chk({31'h0, event_irq_out}, 32'h0);
        wrap_up();
    end
endmodule // testbench
